/* temp_readout_pkg.sv */
// shared constants, types and register map of the temperature readout block
`default_nettype none
package temp_readout_pkg;

  // ----------------------------------------------------------------
  // widths and channel counts
  // ----------------------------------------------------------------
  localparam int NCH = 3;
  localparam int ADC_W = 10;
  localparam int ACC_W = 14;
  localparam int AVG_N = 16;
  localparam int ADDR_W = 12;

  // ----------------------------------------------------------------
  // register indices, byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [9:0] IDX_LOCAL = 10'h027;
  localparam logic [9:0] IDX_TCFG = 10'h04B;
  localparam logic [9:0] IDX_CTRL = 10'h050;
  localparam logic [9:0] IDX_CHMODE = 10'h051;
  localparam logic [9:0] IDX_VAL_BASE = 10'h052;
  localparam logic [9:0] IDX_HI_BASE = 10'h054;
  localparam logic [9:0] IDX_LO_BASE = 10'h057;
  localparam logic [9:0] IDX_WIN = 10'h05A;
  localparam logic [9:0] IDX_ISTAT = 10'h05B;
  localparam logic [9:0] IDX_IMASK = 10'h05C;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_HOT_LSB = 5;
  localparam int CHMODE_REM2_BIT = 2;
  localparam int TCFG_LSB_POS = 6;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CHMODE_RST = 8'h00;
  localparam logic [7:0] HI_RST = 8'h7F;
  localparam logic [7:0] LO_RST = 8'h7E;
  localparam logic [2:0] MASK_RST = 3'h7;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam real T_REMOTE_MS = 9.6;
  localparam int CLK_MHZ = 125;
  localparam int REMOTE_CYCLES = int'($floor(T_REMOTE_MS * 1000.0 * CLK_MHZ));
  localparam int SLOT_CYCLES = REMOTE_CYCLES / AVG_N;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE,
    S_CONV_REQ,
    S_CONV_WAIT,
    S_SLOT,
    S_STORE
  } seq_t;

  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
    logic window;
  } limit_t;

  typedef struct packed {
    logic hot;
    logic evt;
  } cmp_state_t;

  typedef struct packed {
    seq_t st;
    logic [31:0] tmr;
    logic [3:0] cnt;
    logic [1:0] ch;
    logic [ACC_W-1:0] acc;
    logic [NCH-1:0][7:0] val;
    logic [1:0] lsb;
    logic start;
    logic [7:0] chmode;
    logic [NCH-1:0][7:0] hi;
    logic [NCH-1:0][7:0] lo;
    logic [NCH-1:0] win;
    logic [NCH-1:0] stat;
    logic [NCH-1:0] mask;
    logic [31:0] prdata;
    logic slverr;
    logic adc_start;
    logic excite_hi;
    logic [NCH-1:0] cmp_vld;
  } rd_state_t;

endpackage
`default_nettype wire

/* limit_check.sv */
// limit comparator for one measurement channel
`default_nettype none
module limit_check (
  input wire logic clk,
  input wire logic srst,
  input wire logic valid,
  input wire logic [7:0] value,
  input wire temp_readout_pkg::limit_t lim,
  output logic evt,
  output logic hot
);

  temp_readout_pkg::cmp_state_t s, d;
  logic over, under, recov;

  // ----------------------------------------------------------------
  // comparison, signed two's complement
  // ----------------------------------------------------------------
  assign over = $signed(value) > $signed(lim.hi);
  assign under = $signed(value) < $signed(lim.lo);
  assign recov = $signed(value) <= $signed(lim.lo);

  always_comb
  begin
    d = s;
    d.evt = 1'b0;
    if (valid)
    begin
      if (lim.window)
      begin
        d.hot = over || under;
      end
      else if (over)
      begin
        d.hot = 1'b1;
      end
      else if (recov)
      begin
        // only falling to the hysteresis level releases the flag
        d.hot = 1'b0;
      end
      d.evt = d.hot;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s <= '0;
    end
    else
    begin
      s <= d;
    end
  end

  assign evt = s.evt;
  assign hot = s.hot;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  property p_hot_set;
    valid && !lim.window && over |=> hot && evt;
  endproperty
  a_hot_set: assert property (p_hot_set)
    else $error("hot flag not set above high limit");

  property p_hot_hold;
    valid && !lim.window && !over && !recov |=> hot == $past(hot);
  endproperty
  a_hot_hold: assert property (p_hot_hold)
    else $error("hot flag changed inside hysteresis band");

  property p_window;
    valid && lim.window && (over || under) |=> evt;
  endproperty
  a_window: assert property (p_window)
    else $error("out of window value raised no event");

  property p_quiet;
    !valid |=> !evt;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("event without a new result");

endmodule
`default_nettype wire

/* temp_readout.sv */
// temperature readout sequencer, averaging, limits and apb registers
//
// Summary of operation
// - local result in 0x27, extra bits cfg
// - local result signed, one degree steps
// - fractional degrees truncated in stored byte
// - second pair is diode only with bit2
// - remote excitation alternates base and multiple current
// - remote result averages sixteen conversion cycles
// - averaged remote measurement takes nominal 9.6 ms
// - remote results stored signed, same encoding
// - window channel flags above high, below low
// - hot limit sets flag, hysteresis releases it
// - channel mode clears to zero at reset
`default_nettype none
module temp_readout #(
  parameter int unsigned SLOT_CYCLES = temp_readout_pkg::SLOT_CYCLES
) (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [temp_readout_pkg::ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic ADC_DONE,
  input wire logic [temp_readout_pkg::ADC_W-1:0] ADC_DATA,
  output logic ADC_START,
  output logic [1:0] ADC_SEL,
  output logic EXCITE_HIGH,
  output logic REM2_DIODE,
  output logic [7:0] CH_MODE,
  output logic IRQ
);

  localparam int unsigned HALF = SLOT_CYCLES / 2;
  localparam int NCH = temp_readout_pkg::NCH;

  temp_readout_pkg::rd_state_t s, d;
  logic [NCH-1:0] evt;
  logic [NCH-1:0] hot;
  logic [9:0] idx;
  logic setup, access, aligned, hit, wr, rd_clr;
  logic [31:0] rd;

  // ----------------------------------------------------------------
  // address decode helpers
  // ----------------------------------------------------------------
  function automatic logic [9:0] chan_idx(input logic [9:0] base,
                                          input int i);
    chan_idx = base + 10'(i);
  endfunction

  function automatic logic reg_mapped(input logic [9:0] a);
    reg_mapped = 1'b0;
    case (a)
      temp_readout_pkg::IDX_LOCAL,
      temp_readout_pkg::IDX_TCFG,
      temp_readout_pkg::IDX_CTRL,
      temp_readout_pkg::IDX_CHMODE,
      temp_readout_pkg::IDX_WIN,
      temp_readout_pkg::IDX_ISTAT,
      temp_readout_pkg::IDX_IMASK:
        reg_mapped = 1'b1;
      default:
        reg_mapped = 1'b0;
    endcase
    for (int i = 0; i < NCH; i++)
    begin
      if (a == chan_idx(temp_readout_pkg::IDX_HI_BASE, i) ||
          a == chan_idx(temp_readout_pkg::IDX_LO_BASE, i))
        reg_mapped = 1'b1;
    end
    for (int i = 1; i < NCH; i++)
    begin
      if (a == chan_idx(temp_readout_pkg::IDX_VAL_BASE, i - 1))
        reg_mapped = 1'b1;
    end
  endfunction

  assign idx = PADDR[11:2];
  assign aligned = PADDR[1:0] == 2'b00;
  assign hit = aligned && reg_mapped(idx);
  assign setup = PSEL && !PENABLE;
  assign access = PSEL && PENABLE;
  assign wr = access && PWRITE && PSTRB[0] && hit;
  assign rd_clr = access && !PWRITE && hit &&
                  idx == temp_readout_pkg::IDX_ISTAT;

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb
  begin
    rd = 32'h0000_0000;
    case (idx)
      temp_readout_pkg::IDX_LOCAL:
        rd[7:0] = s.val[0];
      temp_readout_pkg::IDX_TCFG:
        rd[temp_readout_pkg::TCFG_LSB_POS +: 2] = s.lsb;
      temp_readout_pkg::IDX_CTRL:
      begin
        rd[temp_readout_pkg::CTRL_START_BIT] = s.start;
        rd[temp_readout_pkg::CTRL_HOT_LSB +: NCH] = hot;
      end
      temp_readout_pkg::IDX_CHMODE:
        rd[7:0] = s.chmode;
      temp_readout_pkg::IDX_WIN:
        rd[NCH-1:0] = s.win;
      temp_readout_pkg::IDX_ISTAT:
        rd[NCH-1:0] = s.stat;
      temp_readout_pkg::IDX_IMASK:
        rd[NCH-1:0] = s.mask;
      default:
        rd = 32'h0000_0000;
    endcase
    for (int i = 0; i < NCH; i++)
    begin
      if (idx == chan_idx(temp_readout_pkg::IDX_HI_BASE, i))
        rd[7:0] = s.hi[i];
      if (idx == chan_idx(temp_readout_pkg::IDX_LO_BASE, i))
        rd[7:0] = s.lo[i];
    end
    for (int i = 1; i < NCH; i++)
    begin
      if (idx == chan_idx(temp_readout_pkg::IDX_VAL_BASE, i - 1))
        rd[7:0] = s.val[i];
    end
    if (!aligned)
      rd = 32'h0000_0000;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    d = s;
    d.adc_start = 1'b0;
    d.cmp_vld = '0;

    case (s.st)
      temp_readout_pkg::S_IDLE:
      begin
        if (s.start)
        begin
          d.ch = 2'd0;
          d.st = temp_readout_pkg::S_CONV_REQ;
        end
      end
      temp_readout_pkg::S_CONV_REQ:
      begin
        d.adc_start = 1'b1;
        d.st = temp_readout_pkg::S_CONV_WAIT;
      end
      temp_readout_pkg::S_CONV_WAIT:
      begin
        if (ADC_DONE && s.ch == 2'd0)
        begin
          // floor to whole degrees, quarter bits kept aside
          d.val[0] = ADC_DATA[9:2];
          d.lsb = ADC_DATA[1:0];
          d.cmp_vld[0] = 1'b1;
          d.st = temp_readout_pkg::S_STORE;
        end
        else if (ADC_DONE)
        begin
          d.acc = s.acc + temp_readout_pkg::ACC_W'($signed(ADC_DATA));
          if (s.cnt == 4'hF)
          begin
            d.st = temp_readout_pkg::S_STORE;
          end
          else
          begin
            d.cnt = s.cnt + 4'h1;
            d.tmr = 32'h0000_0000;
            d.st = temp_readout_pkg::S_SLOT;
          end
        end
      end
      temp_readout_pkg::S_SLOT:
      begin
        // sixteen slots of this length make up one remote measurement
        if (s.tmr == SLOT_CYCLES - 1)
          d.st = temp_readout_pkg::S_CONV_REQ;
        else
          d.tmr = s.tmr + 32'h0000_0001;
      end
      temp_readout_pkg::S_STORE:
      begin
        if (s.ch != 2'd0)
        begin
          // sum of sixteen over sixteen, then drop the quarter bits
          d.val[s.ch] = s.acc[13:6];
          d.cmp_vld[s.ch] = 1'b1;
        end
        d.acc = '0;
        d.cnt = 4'h0;
        d.tmr = 32'h0000_0000;
        if (!s.start)
        begin
          d.st = temp_readout_pkg::S_IDLE;
        end
        else if (s.ch == 2'd0)
        begin
          d.ch = 2'd1;
          d.st = temp_readout_pkg::S_SLOT;
        end
        else if (s.ch == 2'd1 &&
                 s.chmode[temp_readout_pkg::CHMODE_REM2_BIT])
        begin
          d.ch = 2'd2;
          d.st = temp_readout_pkg::S_SLOT;
        end
        else
        begin
          d.ch = 2'd0;
          d.st = temp_readout_pkg::S_CONV_REQ;
        end
      end
      default:
        d.st = temp_readout_pkg::S_IDLE;
    endcase

    // first half of a slot at base current, second half at the multiple
    d.excite_hi = d.st == temp_readout_pkg::S_SLOT &&
                  d.tmr >= HALF;

    // bus side
    if (setup)
    begin
      d.prdata = rd;
      d.slverr = !hit;
    end
    if (wr)
    begin
      case (idx)
        temp_readout_pkg::IDX_CTRL:
          d.start = PWDATA[temp_readout_pkg::CTRL_START_BIT];
        temp_readout_pkg::IDX_CHMODE:
          d.chmode = PWDATA[7:0];
        temp_readout_pkg::IDX_WIN:
          d.win = PWDATA[NCH-1:0];
        temp_readout_pkg::IDX_IMASK:
          d.mask = PWDATA[NCH-1:0];
        default:
          d.start = s.start;
      endcase
      for (int i = 0; i < NCH; i++)
      begin
        if (idx == chan_idx(temp_readout_pkg::IDX_HI_BASE, i))
          d.hi[i] = PWDATA[7:0];
        if (idx == chan_idx(temp_readout_pkg::IDX_LO_BASE, i))
          d.lo[i] = PWDATA[7:0];
      end
    end

    // clear only what the reader was shown; a new event is kept
    d.stat = (s.stat & ~(rd_clr ? s.prdata[NCH-1:0] : {NCH{1'b0}})) | evt;
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      s <= '0;
      s.chmode <= temp_readout_pkg::CHMODE_RST;
      s.hi <= {NCH{temp_readout_pkg::HI_RST}};
      s.lo <= {NCH{temp_readout_pkg::LO_RST}};
      s.mask <= temp_readout_pkg::MASK_RST;
    end
    else
    begin
      s <= d;
    end
  end

  // ----------------------------------------------------------------
  // limit comparators, one per channel
  // ----------------------------------------------------------------
  generate
    for (genvar g = 0; g < NCH; g++)
    begin : g_cmp
      temp_readout_pkg::limit_t lim;
      assign lim = '{hi: s.hi[g], lo: s.lo[g], window: s.win[g]};
      limit_check u_cmp (
        .clk(CLK),
        .srst(SRST),
        .valid(s.cmp_vld[g]),
        .value(s.val[g]),
        .lim(lim),
        .evt(evt[g]),
        .hot(hot[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign PRDATA = s.prdata;
  assign PSLVERR = s.slverr && access;
  assign PREADY = 1'b1;
  assign ADC_START = s.adc_start;
  assign ADC_SEL = s.ch;
  assign EXCITE_HIGH = s.excite_hi;
  assign CH_MODE = s.chmode;
  assign REM2_DIODE = s.chmode[temp_readout_pkg::CHMODE_REM2_BIT];
  assign IRQ = |(s.stat & ~s.mask);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SRST);

  property p_local_store;
    s.st == temp_readout_pkg::S_CONV_WAIT && s.ch == 2'd0 && ADC_DONE
      |=> {s.val[0], s.lsb} == $past(ADC_DATA);
  endproperty
  a_local_store: assert property (p_local_store)
    else $error("local result not stored");

  property p_trunc;
    s.st == temp_readout_pkg::S_CONV_WAIT && s.ch == 2'd0 && ADC_DONE
      |=> $signed({s.val[0], 2'b00}) <= $signed($past(ADC_DATA)) &&
          $signed({s.val[0], 2'b11}) >= $signed($past(ADC_DATA));
  endproperty
  a_trunc: assert property (p_trunc)
    else $error("local result not truncated to whole degrees");

  property p_rem2_gate;
    s.st == temp_readout_pkg::S_STORE && s.ch == 2'd1 &&
      !s.chmode[temp_readout_pkg::CHMODE_REM2_BIT] |=> s.ch != 2'd2;
  endproperty
  a_rem2_gate: assert property (p_rem2_gate)
    else $error("second pair measured while disabled");

  property p_excite;
    s.st == temp_readout_pkg::S_SLOT |-> EXCITE_HIGH == (s.tmr >= HALF);
  endproperty
  a_excite: assert property (p_excite)
    else $error("excitation current phase wrong");

  property p_avg;
    s.st == temp_readout_pkg::S_STORE && s.ch != 2'd0 |-> s.cnt == 4'hF;
  endproperty
  a_avg: assert property (p_avg)
    else $error("remote stored before sixteen conversions");

  property p_slot;
    s.st == temp_readout_pkg::S_SLOT && s.tmr == SLOT_CYCLES - 1
      |=> s.st == temp_readout_pkg::S_CONV_REQ ##1 ADC_START;
  endproperty
  a_slot: assert property (p_slot)
    else $error("slot end did not start a conversion");

  property p_rem_store;
    s.st == temp_readout_pkg::S_STORE && s.ch == 2'd1
      |=> s.val[1] == $past(s.acc[13:6]) && s.cmp_vld[1];
  endproperty
  a_rem_store: assert property (p_rem_store)
    else $error("remote average not stored");

  property p_chmode_rst;
    $past(SRST) |-> CH_MODE == 8'h00;
  endproperty
  a_chmode_rst: assert property (p_chmode_rst)
    else $error("channel mode not cleared by reset");

  property p_irq;
    evt[0] && !d.mask[0] |=> IRQ;
  endproperty
  a_irq: assert property (p_irq)
    else $error("unmasked event gave no interrupt");

endmodule
`default_nettype wire

/* temp_sensor_model.sv */
// behavioural converter model answering the readout sequencer
`default_nettype none
module temp_sensor_model (
  input wire logic CLK,
  input wire logic ADC_START,
  input wire logic [1:0] ADC_SEL,
  input wire logic EXCITE_HIGH,
  input wire logic [9:0] base0,
  input wire logic [9:0] base1,
  input wire logic [9:0] base2,
  output logic ADC_DONE,
  output logic [9:0] ADC_DATA,
  output logic [2:0][15:0] done_cnt,
  output logic [2:0][15:0] start_cnt,
  output int rem_starts,
  output int exc_hi,
  output logic base_seen,
  output int min_gap
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] sel_q = '0;
  logic [1:0] wait_q = '0;
  logic slow_q = '0;
  logic par_q = '0;
  logic hi_q = '0;
  logic [9:0] b;
  int now_t = 0;
  int last_t = -100000;

  initial
  begin
    ADC_DONE = '0;
    ADC_DATA = '0;
    done_cnt = '0;
    start_cnt = '0;
    rem_starts = 0;
    exc_hi = 0;
    base_seen = '0;
    min_gap = 1000000;
  end

  // ----------------------------------------------------------------
  // conversion answer, prompt and slow in turn
  // ----------------------------------------------------------------
  always @(posedge CLK)
  begin
    now_t <= now_t + 1;
    ADC_DONE <= 1'h0;
    // data is not held outside the done cycle
    ADC_DATA <= ~ADC_DATA;
    if (wait_q != 2'h0)
    begin
      wait_q <= wait_q - 2'h1;
      if (wait_q == 2'h1)
      begin
        b = (sel_q == 2'h1) ? base1 : base2;
        ADC_DONE <= 1'h1;
        // remote samples swing around the base so only a true sum fits
        ADC_DATA <= (sel_q == 2'h0) ? base0 : (par_q ? b + 10'h1 : b - 10'h1);
        if (sel_q != 2'h0)
          par_q <= ~par_q;
        done_cnt[sel_q] <= done_cnt[sel_q] + 16'h1;
      end
    end
    else if (ADC_START)
    begin
      sel_q <= ADC_SEL;
      wait_q <= slow_q ? 2'h3 : 2'h1;
      slow_q <= ~slow_q;
      start_cnt[ADC_SEL] <= start_cnt[ADC_SEL] + 16'h1;
      if (ADC_SEL != 2'h0)
      begin
        rem_starts <= rem_starts + 1;
        // the slot before each remote start must have shown the multiple
        if (hi_q)
          exc_hi <= exc_hi + 1;
        hi_q <= 1'h0;
      end
      if (ADC_SEL == 2'h1)
      begin
        if (now_t - last_t < min_gap)
          min_gap <= now_t - last_t;
        last_t <= now_t;
      end
    end
    if (ADC_SEL != 2'h0 && !EXCITE_HIGH)
      base_seen <= 1'h1;
    if (ADC_SEL != 2'h0 && EXCITE_HIGH)
      hi_q <= 1'h1;
  end
endmodule
`default_nettype wire

/* temp_readout_tb.sv */
// self-checking bench for the temperature readout block
`default_nettype none
module temp_readout_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SLOT = 8;
  logic CLK = '0;
  logic SRST = 1'h1;
  logic psel = '0;
  logic penable = '0;
  logic pwrite = '0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [3:0] pstrb = '0;
  logic [31:0] prdata;
  logic pready, pslverr, adc_done, adc_start, excite, rem2, irq;
  logic [9:0] adc_data;
  logic [1:0] adc_sel;
  logic [7:0] ch_mode;
  logic [9:0] base0 = '0;
  logic [9:0] base1 = '0;
  logic [9:0] base2 = '0;
  logic [2:0][15:0] done_cnt, start_cnt;
  int rem_starts, exc_hi, min_gap, i;
  logic base_seen;
  int miscompares = 0;
  int samples_checked = 0;
  logic [15:0] lfsr = 16'h52C6;
  logic [31:0] rd;
  logic er;
  logic [9:0] corner [5] = '{10'h200, 10'h1FF, 10'h002, 10'h3FF, 10'h1F5};
  logic [9:0] hot_v [3] = '{10'h0A0, 10'h064, 10'h03C};
  logic hot_e [3] = '{1'h1, 1'h1, 1'h0};
  logic [9:0] win_v [3] = '{10'h028, 10'h064, 10'h0A0};

  always #4 CLK = ~CLK;

  temp_readout #(.SLOT_CYCLES(SLOT)) i_dut (.CLK(CLK), .SRST(SRST),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .ADC_DONE(adc_done), .ADC_DATA(adc_data),
    .ADC_START(adc_start), .ADC_SEL(adc_sel), .EXCITE_HIGH(excite),
    .REM2_DIODE(rem2), .CH_MODE(ch_mode), .IRQ(irq));

  temp_sensor_model i_model (.CLK(CLK), .ADC_START(adc_start),
    .ADC_SEL(adc_sel), .EXCITE_HIGH(excite), .base0(base0), .base1(base1),
    .base2(base2), .ADC_DONE(adc_done), .ADC_DATA(adc_data),
    .done_cnt(done_cnt), .start_cnt(start_cnt), .rem_starts(rem_starts),
    .exc_hi(exc_hi), .base_seen(base_seen), .min_gap(min_gap));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // floor of quarter degrees, also the sum of sixteen over sixty-four
  function automatic logic [31:0] exp8(input logic [9:0] v);
    return {24'h00_0000, v[9:2]};
  endfunction

  task automatic end_of_test();
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask

  // one apb transfer, entered one edge after any earlier release
  task automatic apb(input logic wr, input logic [9:0] idx,
                     input logic [7:0] d, input logic [3:0] st);
    int n;
    @(posedge CLK);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= {idx, 2'h0};
    pwdata <= {24'h00_0000, d};
    pstrb <= st;
    @(posedge CLK);
    penable <= 1'h1;
    for (n = 0; n < 16; n++)
    begin
      @(posedge CLK);
      if (pready === 1'h1)
        break;
    end
    if (n == 16)
    begin
      miscompares++;
      end_of_test();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    apb(1'h1, idx, d, 4'h1);
  endtask

  task automatic rdchk(input string nm, input logic [9:0] idx,
                       input logic [31:0] e);
    apb(1'h0, idx, 8'h00, 4'h1);
    chk(nm, e, rd);
  endtask

  task automatic wait_done(input int ch, input int n);
    int s;
    int k;
    s = done_cnt[ch];
    for (k = 0; k < 4000; k++)
    begin
      @(posedge CLK);
      if (done_cnt[ch] - s >= n)
        break;
    end
    if (k == 4000)
    begin
      miscompares++;
      end_of_test();
    end
    repeat (4) @(posedge CLK);
  endtask

  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  initial
  begin
    repeat (90000) @(posedge CLK);
    miscompares++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge CLK);
    SRST <= 1'h0;
    rdchk("chmode", temp_readout_pkg::IDX_CHMODE, 32'h0000_0000);
    chk("ch_mode pin", 32'h0000_0000, {24'h00_0000, ch_mode});
    rdchk("hi0", temp_readout_pkg::IDX_HI_BASE, 32'h0000_007F);
    rdchk("lo0", temp_readout_pkg::IDX_LO_BASE, 32'h0000_007E);
    rdchk("imask", temp_readout_pkg::IDX_IMASK, 32'h0000_0007);
    rdchk("unmapped", 10'h060, 32'h0000_0000);
    chk("unmapped err", 32'h0000_0001, {31'h0, er});
    wr(temp_readout_pkg::IDX_IMASK, 8'h00);
    wr(temp_readout_pkg::IDX_HI_BASE, 8'h1E);
    wr(temp_readout_pkg::IDX_LO_BASE, 8'h14);
    wr(temp_readout_pkg::IDX_CTRL, 8'h01);
    // corner codes first, then random ones
    for (i = 0; i < 9; i++)
    begin
      lfsr = lfsr_next(lfsr);
      base0 <= (i < 5) ? corner[i] : lfsr[9:0];
      base1 <= {lfsr[15], lfsr[15], lfsr[14:7]};
      wait_done(1, 32);
      rdchk("local", temp_readout_pkg::IDX_LOCAL, exp8(base0));
      rdchk("tcfg", temp_readout_pkg::IDX_TCFG,
            {24'h00_0000, base0[1:0], 6'h00});
      rdchk("remote1", temp_readout_pkg::IDX_VAL_BASE, exp8(base1));
    end
    chk("pair2 unused", 32'h0, {16'h0000, start_cnt[2]});
    chk("excite high", rem_starts, exc_hi);
    chk("excite base", 32'h1, {31'h0, base_seen});
    chk("slot span", 32'h1, {31'h0, min_gap >= SLOT});
    for (i = 0; i < 3; i++)
    begin
      base0 <= hot_v[i];
      wait_done(0, 3);
      apb(1'h0, temp_readout_pkg::IDX_CTRL, 8'h00, 4'h1);
      chk("hot", {31'h0, hot_e[i]},
          {31'h0, rd[temp_readout_pkg::CTRL_HOT_LSB]});
      if (i == 0)
      begin
        chk("irq", 32'h1, {31'h0, irq});
        wr(temp_readout_pkg::IDX_IMASK, 8'h01);
        @(posedge CLK);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(temp_readout_pkg::IDX_IMASK, 8'h00);
      end
    end
    rdchk("istat clr", temp_readout_pkg::IDX_ISTAT, 32'h0000_0001);
    wait_done(0, 3);
    rdchk("istat", temp_readout_pkg::IDX_ISTAT, 32'h0000_0000);
    chk("irq idle", 32'h0, {31'h0, irq});
    wr(temp_readout_pkg::IDX_WIN, 8'h01);
    for (i = 0; i < 3; i++)
    begin
      base0 <= win_v[i];
      wait_done(0, 3);
      apb(1'h0, temp_readout_pkg::IDX_ISTAT, 8'h00, 4'h1);
      wait_done(0, 3);
      rdchk("window", temp_readout_pkg::IDX_ISTAT, {31'h0, i != 1});
    end
    apb(1'h1, temp_readout_pkg::IDX_CHMODE, 8'h04, 4'h0);
    rdchk("chmode strb", temp_readout_pkg::IDX_CHMODE, 32'h0000_0000);
    wr(temp_readout_pkg::IDX_CHMODE, 8'h04);
    rdchk("chmode", temp_readout_pkg::IDX_CHMODE, 32'h0000_0004);
    chk("diode pin", 32'h1, {31'h0, rem2});
    lfsr = lfsr_next(lfsr);
    base2 <= {lfsr[15], lfsr[15], lfsr[14:7]};
    wait_done(2, 32);
    rdchk("remote2", temp_readout_pkg::IDX_VAL_BASE + 10'h001,
          exp8(base2));
    apb(1'h1, temp_readout_pkg::IDX_LOCAL, 8'h55, 4'h1);
    chk("ro err", 32'h0, {31'h0, er});
    rdchk("local ro", temp_readout_pkg::IDX_LOCAL, exp8(base0));
    end_of_test();
  end
endmodule
`default_nettype wire
